/* rtl/usart_pkg.sv */
package usart_pkg;

	// Register map of the serial transceiver
	localparam logic [7:0] ADDR_STATUS_A = 8'hC0;
	localparam logic [7:0] ADDR_CONTROL_B = 8'hC1;
	localparam logic [7:0] ADDR_FRAME_CFG = 8'hC2;
	localparam logic [7:0] ADDR_BAUD_LOW = 8'hC4;
	localparam logic [7:0] ADDR_BAUD_HIGH = 8'hC5;
	localparam logic [7:0] ADDR_DATA = 8'hC6;

	// Values after reset
	localparam logic [7:0] RST_STATUS_A = 8'h20;
	localparam logic [7:0] RST_CONTROL_B = 8'h00;
	localparam logic [7:0] RST_FRAME_CFG = 8'h06;
	localparam logic [7:0] RST_DATA = 8'h00;
	localparam logic [11:0] RST_BAUD = 12'h000;

	// Bit positions, status register A
	localparam int A_RXC = 7;
	localparam int A_TXC = 6;
	localparam int A_UDRE = 5;
	localparam int A_FE = 4;
	localparam int A_DOR = 3;
	localparam int A_PE = 2;
	localparam int A_U2X = 1;
	localparam int A_MPCM = 0;

	// Bit positions, control register B
	localparam int B_RXCIE = 7;
	localparam int B_TXCIE = 6;
	localparam int B_UDRIE = 5;
	localparam int B_RXEN = 4;
	localparam int B_TXEN = 3;
	localparam int B_SIZE2 = 2;
	localparam int B_RXB8 = 1;
	localparam int B_TXB8 = 0;

	// Bit positions, frame configuration
	localparam int C_STOP = 3;
	localparam int C_POL = 0;

	// Receive FIFO entry layout: status above the nine data bits
	localparam int E_DOR = 11;
	localparam int E_PE = 10;
	localparam int E_FE = 9;
	localparam int E_B8 = 8;

	// Mode and parity encodings
	localparam logic [1:0] MODE_ASYNC = 2'h0;
	localparam logic [1:0] MODE_SYNC = 2'h1;
	localparam logic [1:0] MODE_SPI = 2'h3;
	localparam logic [1:0] PAR_OFF = 2'h0;
	localparam logic [1:0] PAR_EVEN = 2'h2;
	localparam logic [1:0] PAR_ODD = 2'h3;

	// Oversampling counts per bit
	localparam logic [4:0] OS_NORMAL = 5'h10;
	localparam logic [4:0] OS_DOUBLE = 5'h08;

	// Line states, Gray coded along idle-start-data-parity-stop
	typedef enum logic [2:0] {
		LINE_IDLE = 3'h0,
		LINE_START = 3'h1,
		LINE_DATA = 3'h3,
		LINE_PARITY = 3'h2,
		LINE_STOP = 3'h6
	} line_state_t;

	// Character size code to data bit count; reserved codes fall back to eight
	function automatic logic [3:0] char_bits(input logic [2:0] code);
		unique case (code)
			3'h0: char_bits = 4'h5;
			3'h1: char_bits = 4'h6;
			3'h2: char_bits = 4'h7;
			3'h7: char_bits = 4'h9;
			default: char_bits = 4'h8;
		endcase
	endfunction

	// Mask keeping only the low n data bits
	function automatic logic [8:0] data_mask(input logic [3:0] n);
		data_mask = 9'(~(9'h1FF << n));
	endfunction

	// Even parity over the used data bits
	function automatic logic parity_of(input logic [8:0] d, input logic [3:0] n);
		parity_of = ^(d & data_mask(n));
	endfunction

endpackage

/* rtl/serial_tx.sv */
`timescale 1ns/1ns
module serial_tx
	import usart_pkg::*;
(
	input wire logic mclk_i, // System clock
	input wire logic rst_n_i, // Synchronous reset, active low
	input wire logic baud_tick_i, // One pulse per oversample slot
	input wire logic [4:0] os_div_i, // Slots per bit, 16 or 8
	input wire logic [3:0] nbits_i, // Data bits per character
	input wire logic parity_en_i, // Append a parity bit
	input wire logic parity_odd_i, // Odd rather than even parity
	input wire logic two_stop_i, // Send two stop bits
	input wire logic load_valid_i, // Move holding buffer into shifter
	input wire logic [8:0] load_data_i, // Character to send
	output logic load_ready_o, // Shifter empty
	output logic txd_o, // Serial line level
	output logic done_o // Pulse after last stop bit
);

	typedef struct packed {
		line_state_t state;
		logic [8:0] shifter;
		logic [3:0] bits;
		logic [4:0] os;
		logic stop2;
		logic par;
		logic txd;
		logic done;
	} tx_t;

	tx_t s_reg, s_next;
	logic bit_end;

	// A bit ends after os_div slots counted from the load
	assign bit_end = baud_tick_i && (s_reg.os == 5'(os_div_i - 5'h01));
	assign load_ready_o = (s_reg.state == LINE_IDLE);
	assign txd_o = s_reg.txd;
	assign done_o = s_reg.done;

	// Frame sequencing, LSB first
	always_comb begin
		s_next = s_reg;
		s_next.done = 1'b0;
		if (baud_tick_i) begin
			s_next.os = bit_end ? 5'h00 : 5'(s_reg.os + 5'h01);
		end
		unique case (s_reg.state)
			LINE_IDLE: begin
				s_next.txd = 1'b1;
				if (load_valid_i) begin
					// Unused upper bits never reach the line
					s_next.shifter = load_data_i & data_mask(nbits_i);
					s_next.par = parity_of(load_data_i, nbits_i) ^ parity_odd_i;
					s_next.bits = 4'h0;
					s_next.os = 5'h00;
					s_next.txd = 1'b0;
					s_next.state = LINE_START;
				end
			end
			LINE_START: begin
				if (bit_end) begin
					s_next.txd = s_reg.shifter[0];
					s_next.state = LINE_DATA;
				end
			end
			LINE_DATA: begin
				if (bit_end) begin
					s_next.shifter = {1'b0, s_reg.shifter[8:1]};
					s_next.bits = 4'(s_reg.bits + 4'h1);
					if (s_reg.bits == 4'(nbits_i - 4'h1)) begin
						s_next.txd = parity_en_i ? s_reg.par : 1'b1;
						s_next.stop2 = two_stop_i;
						s_next.state = parity_en_i ? LINE_PARITY : LINE_STOP;
					end else begin
						s_next.txd = s_reg.shifter[1];
					end
				end
			end
			LINE_PARITY: begin
				if (bit_end) begin
					s_next.txd = 1'b1;
					s_next.state = LINE_STOP;
				end
			end
			LINE_STOP: begin
				if (bit_end) begin
					if (s_reg.stop2) begin
						s_next.stop2 = 1'b0;
					end else begin
						s_next.done = 1'b1;
						s_next.state = LINE_IDLE;
					end
				end
			end
			default: begin
				s_next.state = LINE_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			s_reg <= '{state: LINE_IDLE, shifter: 9'h000, bits: 4'h0, os: 5'h00,
				stop2: 1'b0, par: 1'b0, txd: 1'b1, done: 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end

endmodule

/* rtl/usart_regs.sv */
// Local design decision: strobed register access.
`timescale 1ns/1ns
// Overview of operation
// - Writes to the data location fill the transmit buffer; reads return receive data.
// - Short characters: transmitter ignores upper bits, receiver returns them as zero.
// - Data writes while the buffer-empty flag is clear are dropped.
// - Enabled transmitter moves buffered data into the empty shifter, then sends it.
// - Two-entry receive FIFO advances on every read of the data location while it holds data.
// - Receive-complete is high while unread data exist; zero after receiver disable.
// - Transmit-complete sets after a frame with no data waiting; ack or write one clears.
// - Buffer-empty flag is one when the buffer can take data, and after reset.
// - Framing error shows a zero first stop bit of the oldest unread character.
// - Overrun sets on a start bit with FIFO full and a character waiting.
// - Parity error shows a failed check of the oldest character, if checking was on.
// - Double speed cuts the asynchronous divisor from 16 to 8; unused in synchronous.
// - Multiprocessor filter drops frames without address information; transmitter unaffected.
// - Each interrupt needs its enable, the global enable and its flag.
// - Receiver enable takes the receive pin; disable flushes the FIFO and error flags.
// - Transmitter enable takes the pin; disable waits until shifter and buffer are empty.
// - Size high bit joins the two low size bits for both directions.
// - In master SPI mode error, speed, filter, size-high and ninth-bit fields do nothing.
// - Frame configuration resets to 0x06.
// - Size codes 000..011 give five to eight bits, 111 gives nine.
// - Mode field: 00 asynchronous, 01 synchronous, 11 master SPI.
// - Parity field: 00 off, 10 even, 11 odd; sender appends, receiver checks.
module usart_regs
	import usart_pkg::*;
(
	input wire logic mclk_i, // System clock
	input wire logic rst_n_i, // Synchronous reset, active low
	input wire logic [7:0] addr_i, // Register address
	input wire logic [7:0] wdata_i, // Write data
	input wire logic wr_i, // Write strobe
	input wire logic rd_i, // Read strobe
	output logic [7:0] rdata_o, // Read data, cycle after strobe
	input wire logic global_irq_en_i, // Processor global interrupt enable
	input wire logic txc_irq_ack_i, // Transmit-complete interrupt taken
	output logic rxc_irq_o, // Receive-complete interrupt
	output logic txc_irq_o, // Transmit-complete interrupt
	output logic udre_irq_o, // Buffer-empty interrupt
	input wire logic rxd_i, // Receive pin level
	output logic rx_pin_owned_o, // Receiver holds the receive pin
	output logic txd_o, // Transmit pin level
	output logic txd_oe_n_o // Transmit pin enable, low while driving
);

	typedef struct packed {
		logic a_txc;
		logic a_u2x;
		logic a_mpcm;
		logic [7:0] ctrl_b;
		logic [7:0] frame_cfg;
		logic [11:0] baud;
		logic [11:0] presc;
		logic [7:0] rdata;
		logic [8:0] tx_buf;
		logic tx_full;
		logic tx_on;
		line_state_t rx_state;
		logic [4:0] rx_os;
		logic [3:0] rx_bits;
		logic [8:0] rx_shift;
		logic rx_par;
		logic [11:0] hold;
		logic hold_full;
		logic [1:0][11:0] fifo;
		logic rd_ptr;
		logic [1:0] cnt;
	} st_t;

	st_t s_reg, s_next;

	logic spi_mode;
	logic async_mode;
	logic [3:0] nbits;
	logic par_en;
	logic par_odd;
	logic [4:0] os_div;
	logic tick;
	logic [11:0] head;
	logic rx_has;
	logic udre;
	logic tx_ready;
	logic tx_go;
	logic tx_done;
	logic [8:0] rx_aligned;
	logic rx_sample;
	logic [4:0] rx_limit;

	// Frame format decode shared by both directions
	assign spi_mode = (s_reg.frame_cfg[7:6] == MODE_SPI);
	assign async_mode = (s_reg.frame_cfg[7:6] == MODE_ASYNC);
	// Size high bit is inert in master SPI, which always moves bytes
	assign nbits = spi_mode ? 4'h8 : char_bits({s_reg.ctrl_b[B_SIZE2], s_reg.frame_cfg[2:1]});
	assign par_en = !spi_mode && (s_reg.frame_cfg[5:4] != PAR_OFF) && s_reg.frame_cfg[5];
	assign par_odd = (s_reg.frame_cfg[5:4] == PAR_ODD);
	// Double speed only applies to asynchronous frames
	assign os_div = (async_mode && s_reg.a_u2x) ? OS_DOUBLE : OS_NORMAL;
	assign tick = (s_reg.presc == 12'h000);

	// Oldest unread entry and flag views
	assign head = s_reg.fifo[s_reg.rd_ptr];
	assign rx_has = (s_reg.cnt != 2'h0);
	assign udre = !s_reg.tx_full;

	// Transmitter hand-off when the shifter is free
	assign tx_go = s_reg.tx_on && s_reg.tx_full && tx_ready;

	// Receive sampling point: mid start bit, then one bit period apart
	assign rx_limit = (s_reg.rx_state == LINE_START) ? 5'((os_div >> 1) - 5'h01) : 5'(os_div - 5'h01);
	assign rx_sample = tick && (s_reg.rx_os == rx_limit);
	// Bits arrive LSB first into the top; shift down to right-align
	assign rx_aligned = 9'(s_reg.rx_shift >> (4'h9 - nbits));

	serial_tx u_tx (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.baud_tick_i(tick),
		.os_div_i(os_div),
		.nbits_i(nbits),
		.parity_en_i(par_en),
		.parity_odd_i(par_odd),
		.two_stop_i(!spi_mode && s_reg.frame_cfg[C_STOP]),
		.load_valid_i(tx_go),
		.load_data_i(s_reg.tx_buf),
		.load_ready_o(tx_ready),
		.txd_o(txd_o),
		.done_o(tx_done)
	);

	// Register, FIFO and receiver next state
	always_comb begin
		s_next = s_reg;
		s_next.rdata = 8'h00;

		// Baud prescaler; writing the low byte restarts it at once
		s_next.presc = tick ? s_reg.baud : 12'(s_reg.presc - 12'h001);

		// Register writes
		if (wr_i) begin
			unique case (addr_i)
				ADDR_STATUS_A: begin
					// Error bits are read-only here
					if (wdata_i[A_TXC]) begin
						s_next.a_txc = 1'b0;
					end
					s_next.a_u2x = wdata_i[A_U2X];
					s_next.a_mpcm = wdata_i[A_MPCM];
				end
				ADDR_CONTROL_B: begin
					// Received ninth bit is not storable
					s_next.ctrl_b = wdata_i & 8'hFD;
					if (wdata_i[B_TXEN]) begin
						s_next.tx_on = 1'b1;
					end
				end
				ADDR_FRAME_CFG: begin
					s_next.frame_cfg = wdata_i;
				end
				ADDR_BAUD_LOW: begin
					s_next.baud = {s_reg.baud[11:8], wdata_i};
					s_next.presc = {s_reg.baud[11:8], wdata_i};
				end
				ADDR_BAUD_HIGH: begin
					s_next.baud = {wdata_i[3:0], s_reg.baud[7:0]};
				end
				ADDR_DATA: begin
					// Full buffer ignores the write, keeping pending data
					if (udre) begin
						s_next.tx_buf = {s_reg.ctrl_b[B_TXB8] && nbits == 4'h9, wdata_i} & data_mask(nbits);
						s_next.tx_full = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end

		// Register reads, answered next cycle
		if (rd_i) begin
			unique case (addr_i)
				ADDR_STATUS_A: begin
					s_next.rdata[A_RXC] = rx_has;
					s_next.rdata[A_TXC] = s_reg.a_txc;
					s_next.rdata[A_UDRE] = udre;
					// Flags follow the oldest entry and vanish in master SPI
					s_next.rdata[A_FE] = rx_has && !spi_mode && head[E_FE];
					s_next.rdata[A_DOR] = rx_has && !spi_mode && head[E_DOR];
					s_next.rdata[A_PE] = rx_has && !spi_mode && head[E_PE];
					s_next.rdata[A_U2X] = s_reg.a_u2x;
					s_next.rdata[A_MPCM] = s_reg.a_mpcm;
				end
				ADDR_CONTROL_B: begin
					s_next.rdata = s_reg.ctrl_b;
					s_next.rdata[B_RXB8] = rx_has && !spi_mode && head[E_B8];
				end
				ADDR_FRAME_CFG: begin
					s_next.rdata = s_reg.frame_cfg;
				end
				ADDR_BAUD_LOW: begin
					s_next.rdata = s_reg.baud[7:0];
				end
				ADDR_BAUD_HIGH: begin
					s_next.rdata = {4'h0, s_reg.baud[11:8]};
				end
				ADDR_DATA: begin
					// A read of this location consumes an entry if one is waiting
					s_next.rdata = head[7:0];
					if (rx_has) begin
						s_next.rd_ptr = !s_reg.rd_ptr;
						s_next.cnt = 2'(s_reg.cnt - 2'h1);
					end
				end
				default: begin
					s_next.rdata = 8'h00;
				end
			endcase
		end

		// Receive line engine
		if (tick) begin
			s_next.rx_os = rx_sample ? 5'h00 : 5'(s_reg.rx_os + 5'h01);
		end
		unique case (s_reg.rx_state)
			LINE_IDLE: begin
				if (!rxd_i) begin
					s_next.rx_os = 5'h00;
					s_next.rx_bits = 4'h0;
					s_next.rx_state = LINE_START;
					// No room anywhere for the character now starting
					if (s_reg.cnt == 2'h2 && s_reg.hold_full) begin
						s_next.hold[E_DOR] = 1'b1;
					end
				end
			end
			LINE_START: begin
				if (rx_sample) begin
					// A high level at mid bit is a glitch, not a start
					s_next.rx_state = rxd_i ? LINE_IDLE : LINE_DATA;
				end
			end
			LINE_DATA: begin
				if (rx_sample) begin
					s_next.rx_shift = {rxd_i, s_reg.rx_shift[8:1]};
					s_next.rx_bits = 4'(s_reg.rx_bits + 4'h1);
					if (s_reg.rx_bits == 4'(nbits - 4'h1)) begin
						s_next.rx_state = par_en ? LINE_PARITY : LINE_STOP;
					end
				end
			end
			LINE_PARITY: begin
				if (rx_sample) begin
					s_next.rx_par = rxd_i;
					s_next.rx_state = LINE_STOP;
				end
			end
			LINE_STOP: begin
				if (rx_sample) begin
					s_next.rx_state = LINE_IDLE;
					// Filter keeps only address frames: ninth bit, or stop bit for short ones
					if (!(s_reg.a_mpcm && !spi_mode && !(nbits == 4'h9 ? rx_aligned[8] : rxd_i))) begin
						if (!s_reg.hold_full) begin
							s_next.hold = {1'b0,
								par_en && (s_reg.rx_par != (parity_of(rx_aligned, nbits) ^ par_odd)),
								!rxd_i,
								rx_aligned};
							s_next.hold_full = 1'b1;
						end
					end
				end
			end
			default: begin
				s_next.rx_state = LINE_IDLE;
			end
		endcase

		// Waiting character drops into the FIFO once there is room
		if (s_next.hold_full && s_next.cnt != 2'h2) begin
			s_next.fifo[s_next.rd_ptr ^ s_next.cnt[0]] = s_next.hold;
			s_next.cnt = 2'(s_next.cnt + 2'h1);
			s_next.hold_full = 1'b0;
			s_next.hold = 12'h000;
		end

		// Receiver off: flush everything, errors with it
		if (!s_reg.ctrl_b[B_RXEN]) begin
			s_next.rx_state = LINE_IDLE;
			s_next.cnt = 2'h0;
			s_next.hold_full = 1'b0;
			s_next.hold = 12'h000;
		end

		// Transmit buffer hand-off and completion
		if (tx_go) begin
			s_next.tx_full = 1'b0;
		end
		if (txc_irq_ack_i) begin
			s_next.a_txc = 1'b0;
		end
		// Setting wins over a same-cycle clear
		if (tx_done && !s_reg.tx_full) begin
			s_next.a_txc = 1'b1;
		end
		// Disable takes hold only when nothing is left to send
		if (!s_next.ctrl_b[B_TXEN] && !s_next.tx_full && tx_ready && !tx_go) begin
			s_next.tx_on = 1'b0;
		end
	end

	// State register; reset values come from the package
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			s_reg <= '0;
			s_reg.a_txc <= RST_STATUS_A[A_TXC];
			s_reg.a_u2x <= RST_STATUS_A[A_U2X];
			s_reg.a_mpcm <= RST_STATUS_A[A_MPCM];
			s_reg.ctrl_b <= RST_CONTROL_B;
			s_reg.frame_cfg <= RST_FRAME_CFG;
			s_reg.baud <= RST_BAUD;
			s_reg.presc <= RST_BAUD;
			s_reg.rdata <= RST_DATA;
			s_reg.tx_full <= !RST_STATUS_A[A_UDRE];
			s_reg.rx_state <= LINE_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs
	assign rdata_o = s_reg.rdata;
	assign rxc_irq_o = s_reg.ctrl_b[B_RXCIE] && global_irq_en_i && rx_has;
	assign txc_irq_o = s_reg.ctrl_b[B_TXCIE] && global_irq_en_i && s_reg.a_txc;
	assign udre_irq_o = s_reg.ctrl_b[B_UDRIE] && global_irq_en_i && udre;
	assign rx_pin_owned_o = s_reg.ctrl_b[B_RXEN];
	assign txd_oe_n_o = !s_reg.tx_on;

endmodule

/* verification/usart_regs_asserts.sv */
`timescale 1ns/1ns
module usart_regs_asserts
	import usart_pkg::*;
(
	input wire logic mclk_i, // System clock
	input wire logic rst_n_i, // Reset, active low
	input wire logic [7:0] addr_i, // Register address
	input wire logic [7:0] wdata_i, // Write data
	input wire logic wr_i, // Write strobe
	input wire logic rd_i, // Read strobe
	input wire logic [7:0] rdata_o, // Read data
	input wire logic global_irq_en_i, // Global enable
	input wire logic txc_irq_ack_i, // Interrupt taken
	input wire logic rxc_irq_o, // Receive interrupt
	input wire logic txc_irq_o, // Transmit interrupt
	input wire logic udre_irq_o, // Buffer-empty interrupt
	input wire logic rxd_i, // Receive pin
	input wire logic rx_pin_owned_o, // Receive pin taken
	input wire logic txd_o, // Transmit pin
	input wire logic txd_oe_n_o // Transmit pin enable
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);

	// Bus answers: data only after a read, unmapped places read zero
	chk_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data outside a read");
	chk_unmapped_read: assert property (rd_i && addr_i == 8'hC3 |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	// Interrupts never bypass the global enable
	chk_irq_gate: assert property ((rxc_irq_o || txc_irq_o || udre_irq_o) |-> global_irq_en_i)
		else $error("interrupt without global enable");
	chk_udre_write: assert property (wr_i && addr_i == ADDR_DATA && udre_irq_o |=> !udre_irq_o)
		else $error("buffer still empty after data write");
	chk_txc_clear: assert property ($fell(txc_irq_o) && global_irq_en_i && $past(global_irq_en_i)
		|-> $past(txc_irq_ack_i) || $past(wr_i))
		else $error("transmit complete dropped by itself");
	// Receive pin ownership only moves on a control write; transmit pin is taken on one, released only at idle
	chk_rx_own: assert property ($changed(rx_pin_owned_o) |-> $past(wr_i) && $past(addr_i) == ADDR_CONTROL_B)
		else $error("receive pin owner changed alone");
	chk_oe_on: assert property ($fell(txd_oe_n_o) |-> $past(wr_i) && $past(addr_i) == ADDR_CONTROL_B
		&& $past(wdata_i[B_TXEN]))
		else $error("transmit pin taken without enable");
	chk_oe_off: assert property ($rose(txd_oe_n_o) |-> txd_o && $past(txd_o))
		else $error("transmit pin released mid frame");
	chk_idle_high: assert property (txd_oe_n_o |-> txd_o)
		else $error("line not idle while released");
	// Shortest bit is eight slots, even at double speed
	chk_low_bit_len: assert property ($fell(txd_o) |=> !txd_o [*7])
		else $error("low bit too short");
endmodule

bind usart_regs usart_regs_asserts chk (.mclk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
	.global_irq_en_i, .txc_irq_ack_i, .rxc_irq_o, .txc_irq_o, .udre_irq_o, .rxd_i, .rx_pin_owned_o,
	.txd_o, .txd_oe_n_o);

/* verification/remote_node.sv */
`timescale 1ns/1ns
module remote_node (
	input wire logic mclk_i, // System clock
	input wire logic txd_i, // Line from the block
	output logic rxd_o // Line into the block
);
	int bit_clks = 16;
	int rx_len = 9;
	logic [11:0] got[$];
	logic [11:0] word;
	// Line is pulled up, so idle reads high
	initial rxd_o = 1'b1;
	// Sample mid-bit; a glitch shorter than half a bit is no start
	always begin
		@(negedge txd_i);
		repeat (bit_clks / 2) @(posedge mclk_i);
		if (txd_i == 1'b0) begin
			word = '0;
			for (int i = 0; i < rx_len; i++) begin
				repeat (bit_clks) @(posedge mclk_i);
				word[i] = txd_i;
			end
			got.push_back(word);
		end
	end
	// Start bit, then len bits lsb first, then back to idle
	task automatic send(input logic [11:0] bits, input int len);
		@(posedge mclk_i);
		rxd_o <= 1'b0;
		repeat (bit_clks) @(posedge mclk_i);
		for (int i = 0; i < len; i++) begin
			rxd_o <= bits[i];
			repeat (bit_clks) @(posedge mclk_i);
		end
		rxd_o <= 1'b1;
	endtask
endmodule

/* verification/usart_regs_test.sv */
`timescale 1ns/1ns
module usart_regs_test;
	import usart_pkg::*;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic gie = 1'b0;
	logic ack = 1'b0;
	logic rxd;
	logic [7:0] rdata_o;
	logic rxc_irq_o, txc_irq_o, udre_irq_o, rx_pin_owned_o, txd_o, txd_oe_n_o;
	int failures = 0;
	int checks_done = 0;
	int cycles = 0;

	usart_regs dut (.mclk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .global_irq_en_i(gie),
		.txc_irq_ack_i(ack), .rxc_irq_o, .txc_irq_o, .udre_irq_o, .rxd_i(rxd), .rx_pin_owned_o, .txd_o,
		.txd_oe_n_o);
	// Released pin floats to its pull-up level
	remote_node mdl (.mclk_i, .txd_i(txd_oe_n_o ? 1'b1 : txd_o), .rxd_o(rxd));

	// Free-running 100 MHz clock
	initial forever #5 mclk_i = ~mclk_i;

	// Hang guard, well above the few thousand cycles of traffic
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			stop_test();
		end
	end

	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Single-cycle strobes; the gap cycle keeps each strobe assigned once per step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk(d, e);
	endtask

	// Poll a status flag as software would, bounded
	task automatic poll(input int b);
		logic [7:0] d;
		d = 8'h00;
		for (int n = 0; n < 3000 && d[b] !== 1'b1; n++) rd(ADDR_STATUS_A, d);
		chk(d[b], 1'b1);
	endtask

	task automatic t_reset;
		rdc(ADDR_STATUS_A, RST_STATUS_A);
		rdc(ADDR_CONTROL_B, RST_CONTROL_B);
		rdc(ADDR_FRAME_CFG, RST_FRAME_CFG);
		rdc(ADDR_DATA, RST_DATA);
		rdc(8'hC3, 8'h00);
		// Baud high nibble only; low write restores the fast prescaler
		wr(ADDR_BAUD_HIGH, 8'hF3);
		rdc(ADDR_BAUD_HIGH, 8'h03);
		wr(ADDR_BAUD_HIGH, 8'h00);
		wr(ADDR_BAUD_LOW, 8'h00);
		chk(txd_oe_n_o, 1'b1);
	endtask

	// Five-bit frames with even then odd parity
	task automatic t_tx_fmt;
		mdl.rx_len = 7;
		wr(ADDR_FRAME_CFG, 8'h20);
		wr(ADDR_CONTROL_B, 8'h08);
		wr(ADDR_DATA, 8'hFF);
		poll(A_TXC);
		wr(ADDR_STATUS_A, 8'h40);
		rdc(ADDR_STATUS_A, 8'h20);
		wr(ADDR_FRAME_CFG, 8'h30);
		wr(ADDR_DATA, 8'hF3);
		poll(A_TXC);
		chk(mdl.got[0], 12'h07F);
		chk(mdl.got[1], 12'h053);
		mdl.got.delete();
	endtask

	// Double speed, dropped write, deferred disable, interrupt service
	task automatic t_tx_main;
		mdl.rx_len = 10;
		mdl.bit_clks = 8;
		@(posedge mclk_i);
		gie <= 1'b1;
		wr(ADDR_FRAME_CFG, RST_FRAME_CFG);
		wr(ADDR_STATUS_A, 8'h42);
		wr(ADDR_CONTROL_B, 8'h6D);
		wr(ADDR_DATA, 8'hA5);
		#1 chk(udre_irq_o, 1'b0);
		poll(A_UDRE);
		wr(ADDR_DATA, 8'h3C);
		wr(ADDR_DATA, 8'h77);
		wr(ADDR_CONTROL_B, 8'h44);
		#1 chk(txd_oe_n_o, 1'b0);
		poll(A_TXC);
		repeat (2) @(posedge mclk_i);
		#1 chk(txd_oe_n_o, 1'b1);
		chk(txc_irq_o, 1'b1);
		@(posedge mclk_i);
		ack <= 1'b1;
		@(posedge mclk_i);
		ack <= 1'b0;
		#1 chk(txc_irq_o, 1'b0);
		chk(mdl.got[0], 12'h3A5);
		chk(mdl.got[1], 12'h33C);
		chk(12'(mdl.got.size()), 12'h002);
		wr(ADDR_STATUS_A, 8'h40);
		mdl.bit_clks = 16;
	endtask

	// FIFO, overrun, frame and parity errors, then flush
	task automatic t_rx;
		wr(ADDR_CONTROL_B, 8'hB0);
		#1 chk(rx_pin_owned_o, 1'b1);
		chk(udre_irq_o, 1'b1);
		for (int i = 1; i < 5; i++) mdl.send({4'h1, 4'(i), 4'(i)}, 9);
		chk(rxc_irq_o, 1'b1);
		rdc(ADDR_STATUS_A, 8'hA0);
		rdc(ADDR_DATA, 8'h11);
		rdc(ADDR_DATA, 8'h22);
		rdc(ADDR_STATUS_A, 8'hA8);
		rdc(ADDR_DATA, 8'h33);
		rdc(ADDR_STATUS_A, 8'h20);
		chk(rxc_irq_o, 1'b0);
		mdl.send(12'h05A, 9);
		wr(ADDR_FRAME_CFG, 8'h26);
		mdl.send(12'h201, 10);
		mdl.send(12'h203, 10);
		rdc(ADDR_STATUS_A, 8'hB0);
		rdc(ADDR_DATA, 8'h5A);
		rdc(ADDR_STATUS_A, 8'hA4);
		rdc(ADDR_DATA, 8'h01);
		rdc(ADDR_STATUS_A, 8'hA0);
		rdc(ADDR_DATA, 8'h03);
		// Parity-failed character must be stored before the flush
		mdl.send(12'h355, 10);
		rdc(ADDR_STATUS_A, 8'hA4);
		wr(ADDR_CONTROL_B, 8'h00);
		#1 chk(rx_pin_owned_o, 1'b0);
		rdc(ADDR_STATUS_A, 8'h20);
		@(posedge mclk_i);
		gie <= 1'b0;
	endtask

	// Nine-bit frames with the address filter on, then mode codes
	task automatic t_mpcm;
		wr(ADDR_FRAME_CFG, RST_FRAME_CFG);
		wr(ADDR_CONTROL_B, 8'h14);
		wr(ADDR_STATUS_A, 8'h01);
		mdl.send(12'h266, 10);
		mdl.send(12'h399, 10);
		rdc(ADDR_CONTROL_B, 8'h16);
		rdc(ADDR_DATA, 8'h99);
		rdc(ADDR_STATUS_A, 8'h21);
		wr(ADDR_FRAME_CFG, 8'h46);
		rdc(ADDR_FRAME_CFG, 8'h46);
		wr(ADDR_FRAME_CFG, 8'hC6);
		rdc(ADDR_FRAME_CFG, 8'hC6);
		// Master SPI: filter inert, framing error hidden
		mdl.send(12'h0AB, 9);
		rdc(ADDR_STATUS_A, 8'hA1);
		rdc(ADDR_DATA, 8'hAB);
	endtask

	task automatic stop_test;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (16) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		t_reset();
		t_tx_fmt();
		t_tx_main();
		t_rx();
		t_mpcm();
		stop_test();
	end
endmodule
